// file: rtl/dcal_pkg.sv
// Shared constants and types for the chip-select to command latency link
// Notes on behaviour
// - Command follows chip select by programmed latency
// - Receivers wake on select, sleep after capture; always on with latency off
// - Receivers stay on through back-to-back commands
// - Field codes: off,3,4,5,6,8; two reserved
// - Programmed latency at least max(3 clocks, 3.748ns)
// - No geardown below the 2666 speed bin
// - Geardown latency must be an even count; odd counts are refused
// - Mode-set to command waits update delay plus latency
// - That wait uses the newly programmed latency
// - Mode-set spacing is update delay plus latency
// - Mode-set spacing uses the newly programmed latency
// - Self refresh accepts only mode-set, calibration and self-refresh exit
package dcal_pkg;
    localparam int unsigned CMD_W          = 4;
    localparam int unsigned ADDR_W         = 17;
    localparam int unsigned LAT_W          = 4;
    // Latency field position inside the mode-register-four address word
    localparam int unsigned LAT_FIELD_LO   = 6;
    localparam int unsigned LAT_FIELD_HI   = 8;
    localparam int unsigned MODE_REG_FOUR  = 4;
    // Mode register select rides on the top address bits
    localparam int unsigned MR_SEL_LO      = 14;
    localparam int unsigned MR_SEL_HI      = 16;
    localparam logic [2:0]  LAT_CODE_OFF   = 3'h0;
    localparam logic [2:0]  LAT_CODE_3     = 3'h1;
    localparam logic [2:0]  LAT_CODE_4     = 3'h2;
    localparam logic [2:0]  LAT_CODE_5     = 3'h3;
    localparam logic [2:0]  LAT_CODE_6     = 3'h4;
    localparam logic [2:0]  LAT_CODE_8     = 3'h5;
    localparam logic [LAT_W-1:0] LAT_CYC_0 = 4'h0;
    localparam logic [LAT_W-1:0] LAT_CYC_3 = 4'h3;
    localparam logic [LAT_W-1:0] LAT_CYC_4 = 4'h4;
    localparam logic [LAT_W-1:0] LAT_CYC_5 = 4'h5;
    localparam logic [LAT_W-1:0] LAT_CYC_6 = 4'h6;
    localparam logic [LAT_W-1:0] LAT_CYC_8 = 4'h8;
    // Timing: least lead time, in picoseconds and clocks at 5 ns period
    localparam int unsigned CLK_PERIOD_PS  = 5000;
    localparam int unsigned CS_LEAD_MIN_PS = 3748;
    localparam int unsigned CS_LEAD_MIN_NCK_FLOOR = 3;
    localparam int unsigned CS_LEAD_MIN_TIME_CYC =
        (CS_LEAD_MIN_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int unsigned CS_LEAD_TIME_MIN_CYC =
        (CS_LEAD_MIN_TIME_CYC > CS_LEAD_MIN_NCK_FLOOR) ?
        CS_LEAD_MIN_TIME_CYC : CS_LEAD_MIN_NCK_FLOOR;
    localparam int unsigned MODE_SET_UPDATE_DELAY_CYC = 24;
    localparam int unsigned GEARDOWN_MIN_RATE = 2666;
    localparam int unsigned WAIT_W = 6;
    // Command encodings
    typedef enum logic [CMD_W-1:0] {
        DCAL_CMD_NOP   = 4'h0,
        DCAL_CMD_MRS   = 4'h1,
        DCAL_CMD_ZQCS  = 4'h2,
        DCAL_CMD_ZQCL  = 4'h3,
        DCAL_CMD_ACT   = 4'h4,
        DCAL_CMD_RD    = 4'h5,
        DCAL_CMD_WR    = 4'h6,
        DCAL_CMD_REF   = 4'h7,
        DCAL_CMD_SRE   = 4'h8,
        DCAL_CMD_SRX   = 4'h9
    } dcal_cmd_t;

    // Field code to latency in clocks; reserved codes map to zero
    function automatic logic [LAT_W-1:0] lat_decode(input logic [2:0] code);
        case (code)
            LAT_CODE_3: lat_decode = LAT_CYC_3;
            LAT_CODE_4: lat_decode = LAT_CYC_4;
            LAT_CODE_5: lat_decode = LAT_CYC_5;
            LAT_CODE_6: lat_decode = LAT_CYC_6;
            LAT_CODE_8: lat_decode = LAT_CYC_8;
            default:    lat_decode = LAT_CYC_0;
        endcase
    endfunction
endpackage

// file: rtl/dcal_if.sv
// Command/address link between controller and device
`timescale 1ns/100ps
`default_nettype none
interface dcal_if;
    logic                          cs_n;
    logic [dcal_pkg::CMD_W-1:0]    cmd;
    logic [dcal_pkg::ADDR_W-1:0]   addr;
    modport ctrl (output cs_n, output cmd, output addr);
    modport dev  (input cs_n, input cmd, input addr);
endinterface
`default_nettype wire

// file: rtl/dcal_device.sv
// Device end: latency decode, delayed capture, receiver gating, command filter
`timescale 1ns/100ps
`default_nettype none
module dcal_device (
    // Clock and reset
    input  wire logic                        mclk,
    input  wire logic                        rst,
    // Link
    dcal_if.dev                              link,
    // Mode inputs
    input  wire logic                        self_refresh,
    // Captured command
    output logic                             cmd_valid,
    output logic [dcal_pkg::CMD_W-1:0]       cmd_out,
    output logic [dcal_pkg::ADDR_W-1:0]      addr_out,
    output logic                             cmd_rejected,
    output logic                             rx_enable,
    output logic [2:0]                       lat_code,
    output logic                             lat_code_bad
);
    localparam int unsigned PIPE = 9;

    logic [PIPE-1:0]                 sel_pipe_reg;
    logic [dcal_pkg::LAT_W-1:0]      lat_cyc;
    logic                            sel_now;
    logic                            take;
    logic                            accept;
    logic [dcal_pkg::CMD_W-1:0]      cmd_in;
    logic [2:0]                      mr_sel;
    logic                            rx_next;
    logic                            mr4_write;

    assign lat_cyc = dcal_pkg::lat_decode(lat_code);
    assign sel_now = ~link.cs_n;
    assign cmd_in  = link.cmd;
    assign mr_sel  = link.addr[dcal_pkg::MR_SEL_HI:dcal_pkg::MR_SEL_LO];

    // Mode-register-four write captured on this edge
    assign mr4_write = take && accept && (cmd_in == dcal_pkg::DCAL_CMD_MRS) &&
                       (mr_sel == 3'(dcal_pkg::MODE_REG_FOUR));

    // Select history; a shift register tracks every command in flight
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            sel_pipe_reg <= '0;
        end else if (mr4_write) begin
            // A new latency would re-read the mode-set select as a second capture;
            // nothing else may be in flight until the extended wait has passed
            sel_pipe_reg <= '0;
        end else begin
            sel_pipe_reg <= {sel_pipe_reg[PIPE-2:0], sel_now};
        end
    end

    // Capture point: select edge when off, else latency clocks later
    always_comb begin
        if (lat_cyc == dcal_pkg::LAT_CYC_0) begin
            take = sel_now;
        end else begin
            take = sel_pipe_reg[lat_cyc - 4'h1];
        end
    end

    // Self refresh lets only mode-set, impedance calibration and self-refresh exit through
    always_comb begin
        if (self_refresh) begin
            accept = (cmd_in == dcal_pkg::DCAL_CMD_MRS)  ||
                     (cmd_in == dcal_pkg::DCAL_CMD_ZQCS) ||
                     (cmd_in == dcal_pkg::DCAL_CMD_ZQCL) ||
                     (cmd_in == dcal_pkg::DCAL_CMD_SRX);
        end else begin
            accept = 1'b1;
        end
    end

    // Captured command outputs
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            cmd_valid    <= 1'b0;
            cmd_out      <= '0;
            addr_out     <= '0;
            cmd_rejected <= 1'b0;
        end else begin
            cmd_valid    <= take && accept;
            cmd_rejected <= take && !accept;
            if (take && accept) begin
                cmd_out  <= cmd_in;
                addr_out <= link.addr;
            end
        end
    end

    // Latency field write; reserved codes are flagged and not applied
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            lat_code     <= dcal_pkg::LAT_CODE_OFF;
            lat_code_bad <= 1'b0;
        end else if (mr4_write) begin
            if (link.addr[dcal_pkg::LAT_FIELD_HI:dcal_pkg::LAT_FIELD_LO] >
                dcal_pkg::LAT_CODE_8) begin
                lat_code_bad <= 1'b1;
            end else begin
                lat_code     <= link.addr[dcal_pkg::LAT_FIELD_HI:dcal_pkg::LAT_FIELD_LO];
                lat_code_bad <= 1'b0;
            end
        end
    end

    // Receivers always on with latency off; else on while any select is pending, off once the last is captured
    always_comb begin
        if (lat_cyc == dcal_pkg::LAT_CYC_0) begin
            rx_next = 1'b1;
        end else begin
            rx_next = sel_now ||
                      ((sel_pipe_reg & ((9'h1 << (lat_cyc - 4'h1)) - 9'h1)) != '0);
        end
    end

    // Registered receiver enable, held on across back-to-back commands
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            rx_enable <= 1'b1;
        end else begin
            rx_enable <= rx_next;
        end
    end
endmodule
`default_nettype wire

// file: rtl/dcal_ctrl.sv
// Controller end: issues command after chip select, paces mode-set commands
`timescale 1ns/100ps
`default_nettype none
module dcal_ctrl #(
    parameter int unsigned RATE_MTS = 3200,
    parameter int unsigned MOD_CYC  = dcal_pkg::MODE_SET_UPDATE_DELAY_CYC
) (
    // Clock and reset
    input  wire logic                        mclk,
    input  wire logic                        rst,
    // Link
    dcal_if.ctrl                             link,
    // User request
    input  wire logic                        req_valid,
    input  wire logic [dcal_pkg::CMD_W-1:0]  req_cmd,
    input  wire logic [dcal_pkg::ADDR_W-1:0] req_addr,
    input  wire logic                        geardown,
    output logic                             req_ready,
    output logic                             cfg_error
);
    typedef enum logic [1:0] {
        DCAL_ST_IDLE = 2'b00,
        DCAL_ST_LEAD = 2'b01,
        DCAL_ST_WAIT = 2'b10
    } dcal_state_t;

    dcal_state_t                     state_reg;
    logic [dcal_pkg::LAT_W-1:0]      lat_reg;
    logic [dcal_pkg::LAT_W-1:0]      lead_cnt_reg;
    logic [dcal_pkg::WAIT_W-1:0]     wait_cnt_reg;
    logic [dcal_pkg::CMD_W-1:0]      cmd_hold_reg;
    logic [dcal_pkg::ADDR_W-1:0]     addr_hold_reg;
    logic [dcal_pkg::LAT_W-1:0]      new_lat;
    logic                            is_mr4;
    logic                            lat_ok;

    assign is_mr4  = (req_cmd == dcal_pkg::DCAL_CMD_MRS) &&
        (req_addr[dcal_pkg::MR_SEL_HI:dcal_pkg::MR_SEL_LO] == 3'(dcal_pkg::MODE_REG_FOUR));
    assign new_lat = dcal_pkg::lat_decode(
        req_addr[dcal_pkg::LAT_FIELD_HI:dcal_pkg::LAT_FIELD_LO]);
    // Accepts off, or at least the least lead time and even under geardown
    assign lat_ok  = (req_addr[dcal_pkg::LAT_FIELD_HI:dcal_pkg::LAT_FIELD_LO] <=
                      dcal_pkg::LAT_CODE_8) &&
                     ((new_lat == dcal_pkg::LAT_CYC_0) ||
                      ((32'(new_lat) >= dcal_pkg::CS_LEAD_TIME_MIN_CYC) &&
                       !(geardown && new_lat[0])));

    // Command sequencer: select, lead gap, then pacing wait
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            state_reg     <= DCAL_ST_IDLE;
            lat_reg       <= dcal_pkg::LAT_CYC_0;
            lead_cnt_reg  <= '0;
            wait_cnt_reg  <= '0;
            cmd_hold_reg  <= '0;
            addr_hold_reg <= '0;
            cfg_error     <= 1'b0;
            req_ready     <= 1'b0;
            link.cs_n     <= 1'b1;
            link.cmd      <= '0;
            link.addr     <= '0;
        end else begin
            link.cs_n <= 1'b1;
            link.cmd  <= dcal_pkg::DCAL_CMD_NOP;
            req_ready <= 1'b0;
            unique case (state_reg)
                DCAL_ST_IDLE: begin
                    req_ready <= 1'b1;
                    if (req_valid && req_ready) begin
                        req_ready <= 1'b0;
                        if ((geardown && RATE_MTS < dcal_pkg::GEARDOWN_MIN_RATE) ||
                            (is_mr4 && !lat_ok)) begin
                            cfg_error <= 1'b1;
                        end else begin
                            cfg_error     <= 1'b0;
                            cmd_hold_reg  <= req_cmd;
                            addr_hold_reg <= req_addr;
                            link.cs_n     <= 1'b0;
                            if (lat_reg == dcal_pkg::LAT_CYC_0) begin
                                link.cmd  <= req_cmd;
                                link.addr <= req_addr;
                                lead_cnt_reg <= '0;
                            end else begin
                                // Full latency count: command lands L edges after select
                                lead_cnt_reg <= lat_reg;
                            end
                            state_reg <= DCAL_ST_LEAD;
                            if (is_mr4) begin
                                lat_reg <= new_lat;
                            end
                        end
                    end
                end
                DCAL_ST_LEAD: begin
                    if (lead_cnt_reg == '0) begin
                        // Only mode-set commands carry the extended wait
                        if (cmd_hold_reg == dcal_pkg::DCAL_CMD_MRS &&
                            (lat_reg != dcal_pkg::LAT_CYC_0)) begin
                            wait_cnt_reg <= dcal_pkg::WAIT_W'(MOD_CYC + 32'(lat_reg));
                            state_reg    <= DCAL_ST_WAIT;
                        end else if (cmd_hold_reg == dcal_pkg::DCAL_CMD_MRS) begin
                            wait_cnt_reg <= dcal_pkg::WAIT_W'(MOD_CYC);
                            state_reg    <= DCAL_ST_WAIT;
                        end else begin
                            state_reg    <= DCAL_ST_IDLE;
                        end
                    end else begin
                        lead_cnt_reg <= lead_cnt_reg - 4'h1;
                        if (lead_cnt_reg == 4'h1) begin
                            link.cmd  <= cmd_hold_reg;
                            link.addr <= addr_hold_reg;
                        end
                    end
                end
                DCAL_ST_WAIT: begin
                    if (wait_cnt_reg <= dcal_pkg::WAIT_W'(2)) begin
                        state_reg <= DCAL_ST_IDLE;
                    end else begin
                        wait_cnt_reg <= wait_cnt_reg - 1'b1;
                    end
                end
                default: state_reg <= DCAL_ST_IDLE;
            endcase
        end
    end
endmodule
`default_nettype wire

// file: dv/dcal_asserts.sv
// Wire-level checker for the select-to-command link
`timescale 1ns/100ps
`default_nettype none
module dcal_asserts #(
    parameter int unsigned MOD_CYC = 24
) (
    // Clock and reset
    input  wire logic                        mclk,
    input  wire logic                        rst,
    // Link
    input  wire logic                        cs_n,
    input  wire logic [dcal_pkg::CMD_W-1:0]  cmd,
    input  wire logic [dcal_pkg::ADDR_W-1:0] addr
);
    default clocking @(posedge mclk); endclocking
    default disable iff (rst);
    logic [3:0] lat_reg;
    logic [3:0] cnt_reg;
    logic [5:0] gap_reg;
    logic       pend_reg;
    logic       seen_reg;
    logic       busy;
    logic       mrs;
    // Any non-idle code on the wire is a command
    assign busy = cmd != dcal_pkg::DCAL_CMD_NOP;
    assign mrs  = cmd == dcal_pkg::DCAL_CMD_MRS;
    // Own copy of the latency, taken from mode-register-four writes seen on the wire
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            lat_reg <= 4'h0;
        end else if (mrs && addr[16:14] == 3'h4) begin
            case (addr[8:6])
                3'h0: lat_reg <= 4'h0;
                3'h1: lat_reg <= 4'h3;
                3'h2: lat_reg <= 4'h4;
                3'h3: lat_reg <= 4'h5;
                3'h4: lat_reg <= 4'h6;
                3'h5: lat_reg <= 4'h8;
                default: lat_reg <= lat_reg;
            endcase
        end
    end
    // Distance from select; saturates so a lost command cannot wrap into a match
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            cnt_reg  <= 4'h0;
            pend_reg <= 1'b0;
        end else if (!cs_n) begin
            cnt_reg  <= 4'h1;
            pend_reg <= !busy;
        end else if (busy) begin
            pend_reg <= 1'b0;
        end else if (pend_reg && cnt_reg != 4'hf) begin
            cnt_reg <= cnt_reg + 4'h1;
        end
    end
    // Cycles since the last mode-set command
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            gap_reg  <= 6'h00;
            seen_reg <= 1'b0;
        end else if (mrs) begin
            gap_reg  <= 6'h01;
            seen_reg <= 1'b1;
        end else if (gap_reg != 6'h3f) begin
            gap_reg <= gap_reg + 6'h01;
        end
    end
    a_cmd_at_latency: assert property (busy && lat_reg != 4'h0 |->
        pend_reg && cnt_reg == lat_reg)
        else $error("command not at programmed distance from select");
    a_latency_off_same: assert property (busy && lat_reg == 4'h0 |-> !cs_n)
        else $error("command not on the select edge with latency off");
    a_code_legal: assert property (mrs && addr[16:14] == 3'h4 |-> addr[8:6] <= 3'h5)
        else $error("reserved latency code sent");
    a_mrs_to_cmd: assert property (busy && !mrs && seen_reg |->
        gap_reg >= MOD_CYC + lat_reg)
        else $error("command too soon after mode-set");
    a_mrs_to_mrs: assert property (mrs && seen_reg |->
        gap_reg >= MOD_CYC + lat_reg)
        else $error("mode-set spacing too short");
    a_select_pulse: assert property ($fell(cs_n) |=> $rose(cs_n))
        else $error("select held longer than one cycle");
    a_no_overlap: assert property (pend_reg |-> cs_n)
        else $error("second select while a command is pending");
    a_cmd_pulse: assert property (busy |=> cmd == dcal_pkg::DCAL_CMD_NOP)
        else $error("command held longer than one cycle");
    c_lat_eight: cover property (busy && lat_reg == 4'h8);
    c_lat_off: cover property (busy && lat_reg == 4'h0);
    c_mrs_pair: cover property (mrs && seen_reg);
endmodule
`default_nettype wire

// file: dv/ddr4_cs_to_command_latency_bench.sv
// Testbench joining controller and device ends of the link
`timescale 1ns/100ps
`default_nettype none
module ddr4_cs_to_command_latency_bench;
    logic mclk, rst, req_valid, geardown, self_refresh;
    logic [3:0] req_cmd, cmd_out;
    logic [16:0] req_addr, addr_out;
    logic req_ready, cfg_error, slow_ready, slow_error;
    logic cmd_valid, cmd_rejected, rx_enable, lat_code_bad;
    logic [2:0] lat_code;
    int err_total, check_count, n;
    int lat_tab[6] = '{0, 3, 4, 5, 6, 8};
    dcal_if link_a();
    dcal_if link_b();
    dcal_ctrl #(.MOD_CYC(4)) dcal_ctrl_i (.mclk(mclk), .rst(rst), .link(link_a),
        .req_valid(req_valid), .req_cmd(req_cmd), .req_addr(req_addr), .geardown(geardown),
        .req_ready(req_ready), .cfg_error(cfg_error));
    // Slow-rate controller sees the same requests; only its refusal is judged
    dcal_ctrl #(.RATE_MTS(2400), .MOD_CYC(4)) dcal_ctrl_slow_i (.mclk(mclk), .rst(rst),
        .link(link_b), .req_valid(req_valid), .req_cmd(req_cmd), .req_addr(req_addr),
        .geardown(geardown), .req_ready(slow_ready), .cfg_error(slow_error));
    dcal_device dcal_device_i (.mclk(mclk), .rst(rst), .link(link_a),
        .self_refresh(self_refresh), .cmd_valid(cmd_valid), .cmd_out(cmd_out),
        .addr_out(addr_out), .cmd_rejected(cmd_rejected), .rx_enable(rx_enable),
        .lat_code(lat_code), .lat_code_bad(lat_code_bad));
    dcal_asserts #(.MOD_CYC(4)) dcal_asserts_i (.mclk(mclk), .rst(rst),
        .cs_n(link_a.cs_n), .cmd(link_a.cmd), .addr(link_a.addr));
    // Clock and watchdog
    initial begin
        mclk = 1'b0;
        forever #2.5 mclk = ~mclk;
    end
    initial begin
        repeat (30000) @(posedge mclk);
        err_total++;
        report_and_stop();
    end
    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", check_count, err_total);
        if (err_total == 0 && check_count > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    task automatic chk_val(input string what, input logic [16:0] exp, input logic [16:0] got);
        check_count++;
        if (got !== exp) begin
            err_total++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic chk_bit(input string what, input logic exp, input logic got);
        chk_val(what, {16'h0000, exp}, {16'h0000, got});
    endtask
    // One request; n ends as cycles to the device answer, 40 when nothing arrives
    task automatic send(input logic [3:0] c, input logic [16:0] a);
        int i;
        i = 0;
        while ((req_ready & slow_ready) !== 1'b1 && i < 200) begin
            @(posedge mclk);
            #1 i++;
        end
        if (i == 200) begin
            err_total++;
            report_and_stop();
        end
        req_valid = 1'b1;
        req_cmd = c;
        req_addr = a;
        @(posedge mclk);
        #1 req_valid = 1'b0;
        n = 1;
        while (cmd_valid !== 1'b1 && cmd_rejected !== 1'b1 && n < 40) begin
            @(posedge mclk);
            #1 n++;
        end
    endtask
    task automatic mr4(input logic [2:0] code);
        send(dcal_pkg::DCAL_CMD_MRS, {3'h4, 5'h00, code, 6'h00});
    endtask
    task automatic t_lat_off();
        send(dcal_pkg::DCAL_CMD_RD, 17'h1a5c3);
        chk_val("latency off", 17'h00002, n[16:0]);
        chk_val("addr", 17'h1a5c3, addr_out);
        chk_val("cmd", 17'h00005, {13'h0000, cmd_out});
    endtask
    task automatic t_codes();
        int prev;
        prev = 0;
        for (int c = 1; c < 6; c++) begin
            mr4(c[2:0]);
            chk_val("mrs latency", 17'(lat_tab[prev] + 2), n[16:0]);
            // A latency change must not turn the mode-set select into a second capture
            for (int k = 0; k < 4; k++) begin
                @(posedge mclk);
                #1 chk_bit("stray capture", 1'b0, cmd_valid);
            end
            chk_val("lat code", c[16:0], {14'h0000, lat_code});
            send(dcal_pkg::DCAL_CMD_WR, 17'h00f00 + c[16:0]);
            chk_val("latency", 17'(lat_tab[c] + 2), n[16:0]);
            chk_val("addr", 17'h00f00 + c[16:0], addr_out);
            prev = c;
        end
        repeat (3) @(posedge mclk);
        #1 chk_bit("rx off", 1'b0, rx_enable);
    endtask
    task automatic t_refused();
        for (int c = 6; c < 8; c++) begin
            mr4(c[2:0]);
            chk_val("nothing sent", 17'h00028, n[16:0]);
            chk_bit("cfg error", 1'b1, cfg_error);
            chk_val("lat kept", 17'h00005, {14'h0000, lat_code});
            chk_bit("code bad", 1'b0, lat_code_bad);
        end
        geardown = 1'b1;
        mr4(3'h1);
        chk_bit("odd refused", 1'b1, cfg_error);
        mr4(3'h4);
        chk_bit("even taken", 1'b0, cfg_error);
        chk_bit("slow geardown", 1'b1, slow_error);
        geardown = 1'b0;
    endtask
    task automatic t_selfref();
        logic [3:0] cmds[6] = '{4'h4, 4'h5, 4'h6, 4'h7, 4'h2, 4'h3};
        self_refresh = 1'b1;
        for (int k = 0; k < 6; k++) begin
            send(cmds[k], 17'h00400);
            chk_bit("accepted", k > 3, cmd_valid);
            chk_bit("rejected", k < 4, cmd_rejected);
        end
        self_refresh = 1'b0;
    endtask
    // Main sequence
    initial begin
        rst = 1'b1;
        req_valid = 1'b0;
        req_cmd = 4'h0;
        req_addr = 17'h00000;
        geardown = 1'b0;
        self_refresh = 1'b0;
        repeat (12) @(posedge mclk);
        #1 rst = 1'b0;
        repeat (2) @(posedge mclk);
        #1 chk_val("reset code", 17'h00000, {14'h0000, lat_code});
        t_lat_off();
        t_codes();
        t_refused();
        t_selfref();
        report_and_stop();
    end
endmodule
`default_nettype wire
